// *** common/msu_consts.svh ***
// Timing counts and field constants for the multiply and saturate unit
`ifndef MSU_CONSTS_SVH
`define MSU_CONSTS_SVH
// ****************************************
// Cycle counts per class, without interlock
// ****************************************
`define MSU_CYC_WORD        4'h2
`define MSU_CYC_WORD_FLAGS  4'h4
`define MSU_CYC_LONG        4'h3
`define MSU_CYC_LONG_FLAGS  4'h5
`define MSU_CYC_HALF        4'h1
`define MSU_CYC_HALF_LONG   4'h2
`define MSU_CYC_SAT         4'h1
`define MSU_CYC_OTHER       4'h1
`define MSU_CYC_INTERLOCK   4'h1
`define MSU_BUS_IDLE        4'ha
// ****************************************
// Multiplier stepping
// ****************************************
`define MSU_STEP_BITS       7'h10
`define MSU_STEPS_WIDE      2'h2
`define MSU_STEPS_NARROW    2'h1
`define MSU_SAT_MAX         32'h7fffffff
`define MSU_SAT_MIN         32'h80000000
`endif

// *** common/msu_pkg.sv ***
// Types shared by the multiply and saturate unit
`default_nettype none
package msu_pkg;
  typedef enum logic [2:0] {
    msu_word      = 3'h0,
    msu_long      = 3'h1,
    msu_half      = 3'h2,
    msu_word_half = 3'h3,
    msu_half_long = 3'h4,
    msu_sat       = 3'h5,
    msu_other     = 3'h6
  } msu_op_t;

  typedef enum logic [1:0] {
    msu_idle = 2'b01,
    msu_run  = 2'b10
  } msu_state_t;

  typedef struct packed {
    msu_op_t    op;
    logic       set_flags;
    logic       accumulate;
    logic       is_signed;
    logic       subtract;
    logic       doubling;
    logic       x_top;
    logic       y_top;
    logic       compressed;
    logic [3:0] dst_lo;
    logic [3:0] dst_hi;
    logic       dst_hi_en;
    logic [3:0] src_a;
    logic [3:0] src_b;
    logic [3:0] src_c;
    logic [3:0] src_c_hi;
    logic       use_a;
    logic       use_b;
    logic       use_c;
    logic       use_c_hi;
  } msu_issue_t;

  typedef struct packed {
    logic [31:0] a_bus;
    logic [31:0] b_bus;
    logic [31:0] c_bus;
    logic [31:0] c_hi_bus;
  } msu_oper_t;

  typedef struct packed {
    logic fetch_request_n;
    logic fetch_sequential;
    logic load_store_request_n;
    logic load_store_sequential;
  } msu_bus_t;
endpackage
`default_nettype wire

// *** rtl/msu_core.sv ***
// Multiply and saturating arithmetic unit with cycle timing and interlocks
// Function
// - All multiply cycles but the last are internal; the last fetches sequentially.
// - Execute reads A and B buses, sums partial products sixteen multiplier bits per cycle.
// - Memory adds partial product, optional C-bus accumulate and previous-step feedback.
// - In compressed state only flag-setting word multiply and accumulate are accepted.
// - Multiply result valid after Memory; dependent next instruction stalls until then.
// - Next multiply-accumulate using the result as accumulator is not stalled.
// - Plain word multiply takes 2 cycles, 3 when interlocked; earlier cycles internal.
// - Flag-setting word multiply always takes four cycles and never stalls successors.
// - Plain long multiplies take 3 cycles, 4 when interlocked.
// - Flag-setting long multiplies always take five cycles and never stall successors.
// - Halfword and word-by-halfword forms take 1 cycle, 2 with internal first when stalled.
// - Halfword product with long accumulate takes 2 cycles, 3 when interlocked.
// - Saturating add, subtract and doubling forms take one cycle, 2 when interlocked, full-width state only.
// - Successor needing saturating result in first Execute stalls one cycle.
// - Successor needing saturating result only in first Memory is not stalled.
`include "msu_consts.svh"
`default_nettype none
module msu_core #(
  parameter int CNT_W = 4
) (
  input  wire logic               clk_i,
  input  wire logic               sys_rst_i,
  input  wire logic               issue_valid_i,
  input  wire msu_pkg::msu_issue_t issue_i,
  input  wire msu_pkg::msu_oper_t oper_i,
  input  wire logic [31:0]        prefetch_addr_i,
  output logic                    ready_o,
  output logic                    stall_o,
  output logic                    illegal_o,
  output msu_pkg::msu_bus_t       bus_o,
  output logic [31:0]             fetch_addr_o,
  output logic [63:0]             result_o,
  output logic                    result_valid_o,
  output logic [1:0]              flags_o,
  output logic                    saturated_o
);
  generate
    if (CNT_W < 3) begin : g_chk
      $error("CNT_W too small for the cycle counts");
    end
  endgenerate

  // ****************************************
  // Control state
  // ****************************************
  msu_pkg::msu_state_t state;
  msu_pkg::msu_state_t next_state;
  logic [CNT_W-1:0]    cnt;
  logic [CNT_W-1:0]    next_cnt;
  msu_pkg::msu_issue_t cur;
  msu_pkg::msu_issue_t next_cur;
  logic                waiting;
  logic                next_waiting;
  logic [1:0]          step;
  logic [1:0]          next_step;
  logic                pend_valid;
  logic                next_pend_valid;
  logic                pend_sat;
  logic                next_pend_sat;
  logic [3:0]          pend_lo;
  logic [3:0]          next_pend_lo;
  logic [3:0]          pend_hi;
  logic [3:0]          next_pend_hi;
  logic                pend_hi_en;
  logic                next_pend_hi_en;
  logic                next_ready;
  logic                next_stall;
  logic                next_illegal;
  msu_pkg::msu_bus_t   next_bus;
  logic [31:0]         next_fetch_addr;

  logic                accept;
  logic                legal;
  logic                hit_ex;
  logic                hit_mem;
  logic                is_mult;
  logic                interlock;
  logic [CNT_W-1:0]    base_cyc;
  logic                last;

  function automatic logic hit(input logic [3:0] r, input logic [3:0] lo,
                               input logic [3:0] hi, input logic hi_en);
    hit = (r == lo) || (hi_en && (r == hi));
  endfunction

  always_comb begin
    accept   = issue_valid_i && ready_o;
    is_mult  = issue_i.op != msu_pkg::msu_sat && issue_i.op != msu_pkg::msu_other;
    legal    = !issue_i.compressed ||
               (issue_i.op == msu_pkg::msu_word && issue_i.set_flags);
    hit_ex   = (issue_i.use_a && hit(issue_i.src_a, pend_lo, pend_hi, pend_hi_en)) ||
               (issue_i.use_b && hit(issue_i.src_b, pend_lo, pend_hi, pend_hi_en));
    hit_mem  = (issue_i.use_c && hit(issue_i.src_c, pend_lo, pend_hi, pend_hi_en)) ||
               (issue_i.use_c_hi && hit(issue_i.src_c_hi, pend_lo, pend_hi, pend_hi_en));
    interlock = pend_valid && !(is_mult && issue_i.set_flags) &&
                (hit_ex ||
                 (!pend_sat && hit_mem &&
                  !(is_mult && issue_i.accumulate)));
    unique case (issue_i.op)
      msu_pkg::msu_word:
        base_cyc = issue_i.set_flags ? CNT_W'(`MSU_CYC_WORD_FLAGS)
                                     : CNT_W'(`MSU_CYC_WORD);
      msu_pkg::msu_long:
        base_cyc = issue_i.set_flags ? CNT_W'(`MSU_CYC_LONG_FLAGS)
                                     : CNT_W'(`MSU_CYC_LONG);
      msu_pkg::msu_half,
      msu_pkg::msu_word_half: base_cyc = CNT_W'(`MSU_CYC_HALF);
      msu_pkg::msu_half_long: base_cyc = CNT_W'(`MSU_CYC_HALF_LONG);
      msu_pkg::msu_sat:       base_cyc = CNT_W'(`MSU_CYC_SAT);
      default:                base_cyc = CNT_W'(`MSU_CYC_OTHER);
    endcase
    last = state == msu_pkg::msu_run && cnt == CNT_W'(1);

    next_state      = state;
    next_cnt        = cnt;
    next_cur        = cur;
    next_waiting    = 1'b0;
    next_step       = step;
    next_pend_valid = pend_valid;
    next_pend_sat   = pend_sat;
    next_pend_lo    = pend_lo;
    next_pend_hi    = pend_hi;
    next_pend_hi_en = pend_hi_en;
    next_illegal    = 1'b0;
    next_fetch_addr = fetch_addr_o;
    if (state == msu_pkg::msu_run) begin
      next_cnt = cnt - CNT_W'(1);
      if (!waiting && step != 2'h3) begin
        next_step = step + 2'h1;
      end
      if (last) begin
        next_state      = msu_pkg::msu_idle;
        next_pend_valid = 1'b0;
      end
    end
    if (accept) begin
      next_pend_valid = 1'b0;
      if (!legal) begin
        next_illegal = 1'b1;
      end else begin
        next_state      = msu_pkg::msu_run;
        next_cur        = issue_i;
        next_step       = 2'h0;
        next_waiting    = interlock;
        next_cnt        = base_cyc + (interlock ? CNT_W'(`MSU_CYC_INTERLOCK) : '0);
        next_fetch_addr = prefetch_addr_i;
        next_pend_valid = !(is_mult && issue_i.set_flags) &&
                          issue_i.op != msu_pkg::msu_other;
        next_pend_sat   = issue_i.op == msu_pkg::msu_sat;
        next_pend_lo    = issue_i.dst_lo;
        next_pend_hi    = issue_i.dst_hi;
        next_pend_hi_en = issue_i.dst_hi_en;
      end
    end
    next_ready = next_state == msu_pkg::msu_idle || next_cnt == CNT_W'(1);
    next_stall = next_waiting;
    next_bus.fetch_request_n       = !(next_state == msu_pkg::msu_run &&
                                       next_cnt == CNT_W'(1));
    next_bus.fetch_sequential      = !next_bus.fetch_request_n;
    next_bus.load_store_request_n  = 1'b1;
    next_bus.load_store_sequential = 1'b0;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state        <= msu_pkg::msu_idle;
      cnt          <= '0;
      cur          <= '0;
      waiting      <= 1'b0;
      step         <= 2'h0;
      pend_valid   <= 1'b0;
      pend_sat     <= 1'b0;
      pend_lo      <= 4'h0;
      pend_hi      <= 4'h0;
      pend_hi_en   <= 1'b0;
      ready_o      <= 1'b1;
      stall_o      <= 1'b0;
      illegal_o    <= 1'b0;
      bus_o        <= `MSU_BUS_IDLE;
      fetch_addr_o <= 32'h00000000;
    end else begin
      state        <= next_state;
      cnt          <= next_cnt;
      cur          <= next_cur;
      waiting      <= next_waiting;
      step         <= next_step;
      pend_valid   <= next_pend_valid;
      pend_sat     <= next_pend_sat;
      pend_lo      <= next_pend_lo;
      pend_hi      <= next_pend_hi;
      pend_hi_en   <= next_pend_hi_en;
      ready_o      <= next_ready;
      stall_o      <= next_stall;
      illegal_o    <= next_illegal;
      bus_o        <= next_bus;
      fetch_addr_o <= next_fetch_addr;
    end
  end

  // ****************************************
  // Datapath
  // ****************************************
  msu_pkg::msu_oper_t opr;
  msu_pkg::msu_oper_t next_opr;
  logic [63:0]        pacc;
  logic [63:0]        next_pacc;
  logic [63:0]        next_result;
  logic               next_result_valid;
  logic [1:0]         next_flags;
  logic               next_saturated;

  logic [1:0]         nsteps;
  logic [32:0]        mcand;
  logic [16:0]        chunk;
  logic signed [49:0] part;
  logic [63:0]        part64;
  logic [63:0]        prod;
  logic [63:0]        acc;
  logic [63:0]        sum;
  logic [32:0]        dbl;
  logic [31:0]        sat_b;
  logic [32:0]        sat_sum;
  logic [31:0]        sat_res;
  logic               clip_b;
  logic               clip_r;

  function automatic logic [31:0] clamp(input logic [32:0] v, output logic clip);
    clip = v[32] != v[31];
    clamp = !clip ? v[31:0] : (v[32] ? `MSU_SAT_MIN : `MSU_SAT_MAX);
  endfunction

  always_comb begin
    nsteps = (cur.op == msu_pkg::msu_word || cur.op == msu_pkg::msu_long) ?
             `MSU_STEPS_WIDE : `MSU_STEPS_NARROW;
    // Multiplicand from the A bus, multiplier slice from the B bus
    if (cur.op == msu_pkg::msu_word || cur.op == msu_pkg::msu_long ||
        cur.op == msu_pkg::msu_word_half) begin
      mcand = {cur.is_signed && opr.a_bus[31], opr.a_bus};
    end else begin
      mcand = cur.x_top ? {{17{opr.a_bus[31]}}, opr.a_bus[31:16]}
                        : {{17{opr.a_bus[15]}}, opr.a_bus[15:0]};
    end
    if (nsteps == `MSU_STEPS_WIDE) begin
      chunk = step[0] ? {cur.is_signed && opr.b_bus[31], opr.b_bus[31:16]}
                      : {1'b0, opr.b_bus[15:0]};
    end else begin
      chunk = cur.y_top ? {opr.b_bus[31], opr.b_bus[31:16]}
                        : {opr.b_bus[15], opr.b_bus[15:0]};
    end
    part   = $signed(mcand) * $signed(chunk);
    part64 = (waiting || step >= nsteps) ? 64'h0 :
             {{14{part[49]}}, part} << (step[0] ? `MSU_STEP_BITS : 7'h00);
    prod   = pacc + part64;
    if (cur.op == msu_pkg::msu_word_half) begin
      prod = {{16{prod[63]}}, prod[63:16]};
    end
    if (cur.op == msu_pkg::msu_long || cur.op == msu_pkg::msu_half_long) begin
      acc = {opr.c_hi_bus, opr.c_bus};
    end else begin
      acc = {32'h00000000, opr.c_bus};
    end
    sum = prod + (cur.accumulate ? acc : 64'h0);

    dbl     = {opr.b_bus, 1'b0};
    sat_b   = clamp({opr.b_bus[31], dbl[31:0]}, clip_b);
    if (!cur.doubling) begin
      sat_b  = opr.b_bus;
      clip_b = 1'b0;
    end
    sat_sum = cur.subtract ? {opr.a_bus[31], opr.a_bus} - {sat_b[31], sat_b}
                           : {opr.a_bus[31], opr.a_bus} + {sat_b[31], sat_b};
    sat_res = clamp(sat_sum, clip_r);

    next_opr          = opr;
    next_pacc         = prod;
    next_result       = result_o;
    next_result_valid = 1'b0;
    next_flags        = flags_o;
    next_saturated    = 1'b0;
    if (accept && legal && !interlock) begin
      next_opr  = oper_i;
      next_pacc = 64'h0;
    end else if (waiting) begin
      next_opr  = oper_i;
      next_pacc = 64'h0;
    end
    if (last && cur.op != msu_pkg::msu_other) begin
      next_result_valid = 1'b1;
      if (cur.op == msu_pkg::msu_sat) begin
        next_result    = {32'h00000000, sat_res};
        next_saturated = clip_b || clip_r;
      end else if (cur.op == msu_pkg::msu_long || cur.op == msu_pkg::msu_half_long) begin
        next_result = sum;
        if (cur.set_flags) begin
          next_flags = {sum[63], sum == 64'h0};
        end
      end else begin
        next_result = {32'h00000000, sum[31:0]};
        if (cur.set_flags) begin
          next_flags = {sum[31], sum[31:0] == 32'h00000000};
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      opr            <= '0;
      pacc           <= 64'h0;
      result_o       <= 64'h0;
      result_valid_o <= 1'b0;
      flags_o        <= 2'h0;
      saturated_o    <= 1'b0;
    end else begin
      opr            <= next_opr;
      pacc           <= next_pacc;
      result_o       <= next_result;
      result_valid_o <= next_result_valid;
      flags_o        <= next_flags;
      saturated_o    <= next_saturated;
    end
  end
endmodule
`default_nettype wire

// *** bench/msu_core_chk.sv ***
// Checker of cycle timing for the multiply and saturate unit
`default_nettype none
module msu_core_chk #(
  parameter int CNT_W = 4
) (
  input wire logic                clk_i,
  input wire logic                sys_rst_i,
  input wire logic                issue_valid_i,
  input wire msu_pkg::msu_issue_t issue_i,
  input wire logic                ready_o,
  input wire logic                stall_o,
  input wire logic                illegal_o,
  input wire msu_pkg::msu_bus_t   bus_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // ****************************************
  // Classes and bus steps
  // ****************************************
  logic op_w;
  logic op_l;
  logic op_hl;
  logic op_sh;
  logic fl;
  assign op_w  = issue_i.op == msu_pkg::msu_word;
  assign op_l  = issue_i.op == msu_pkg::msu_long;
  assign op_hl = issue_i.op == msu_pkg::msu_half_long;
  assign op_sh = issue_i.op inside {msu_pkg::msu_half, msu_pkg::msu_word_half, msu_pkg::msu_sat};
  assign fl    = issue_i.set_flags;
  sequence s_i;
    bus_o.fetch_request_n && !bus_o.fetch_sequential && !ready_o;
  endsequence
  sequence s_s;
    !bus_o.fetch_request_n && bus_o.fetch_sequential && ready_o;
  endsequence
  sequence s_go(ok);
    issue_valid_i && ready_o && !issue_i.compressed && ok;
  endsequence
  property p_word;
    s_go(op_w && !fl) ##1 !stall_o |-> s_i ##1 s_s;
  endproperty
  a_word: assert property (p_word) else $error("word multiply timing wrong");
  property p_wlock;
    s_go((op_w && !fl) || op_hl) ##1 stall_o |-> s_i ##1 s_i ##1 s_s;
  endproperty
  a_wlock: assert property (p_wlock) else $error("interlocked timing wrong");
  property p_wflag;
    s_go(op_w && fl) |=> !stall_o ##0 s_i[*3] ##1 s_s;
  endproperty
  a_wflag: assert property (p_wflag) else $error("flag word multiply timing wrong");
  property p_long;
    s_go(op_l && !fl) ##1 !stall_o |-> s_i[*2] ##1 s_s;
  endproperty
  a_long: assert property (p_long) else $error("long multiply timing wrong");
  property p_llock;
    s_go(op_l && !fl) ##1 stall_o |-> s_i[*3] ##1 s_s;
  endproperty
  a_llock: assert property (p_llock) else $error("interlocked long timing wrong");
  property p_lflag;
    s_go(op_l && fl) |=> !stall_o ##0 s_i[*4] ##1 s_s;
  endproperty
  a_lflag: assert property (p_lflag) else $error("flag long multiply timing wrong");
  property p_short;
    s_go(op_sh) ##1 !stall_o |-> s_s;
  endproperty
  a_short: assert property (p_short) else $error("single cycle op timing wrong");
  property p_slock;
    s_go(op_sh) ##1 stall_o |-> s_i ##1 s_s;
  endproperty
  a_slock: assert property (p_slock) else $error("stalled short op timing wrong");
  property p_hlong;
    s_go(op_hl) ##1 !stall_o |-> s_i ##1 s_s;
  endproperty
  a_hlong: assert property (p_hlong) else $error("half long accumulate timing wrong");
  property p_refuse;
    issue_valid_i && ready_o && issue_i.compressed && !(op_w && fl)
      |=> illegal_o && bus_o.fetch_request_n;
  endproperty
  a_refuse: assert property (p_refuse) else $error("compressed op not refused");
  property p_data;
    bus_o.load_store_request_n && !bus_o.load_store_sequential;
  endproperty
  a_data: assert property (p_data) else $error("data side not internal");
endmodule
bind msu_core msu_core_chk #(.CNT_W(CNT_W)) i_msu_core_chk (
  .clk_i        (clk_i),
  .sys_rst_i    (sys_rst_i),
  .issue_valid_i(issue_valid_i),
  .issue_i      (issue_i),
  .ready_o      (ready_o),
  .stall_o      (stall_o),
  .illegal_o    (illegal_o),
  .bus_o        (bus_o)
);
`default_nettype wire

// *** bench/msu_mem_model.sv ***
// Memory side model that serves sequential fetches
`default_nettype none
module msu_mem_model (
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  input  wire msu_pkg::msu_bus_t bus_i,
  input  wire logic [31:0]       fetch_addr_i,
  output logic [31:0]            fetch_count_o,
  output logic [31:0]            fetch_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Between fetches the read data toggles so stale data never looks valid
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fetch_count_o <= 32'h0;
      fetch_data_o  <= 32'h0;
    end else if (!bus_i.fetch_request_n) begin
      fetch_count_o <= fetch_count_o + 32'h1;
      fetch_data_o  <= ~fetch_addr_i;
    end else begin
      fetch_data_o  <= ~fetch_data_o;
    end
  end
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for the multiply and saturate unit
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam msu_pkg::msu_op_t op_w = msu_pkg::msu_word;
  localparam msu_pkg::msu_op_t op_l = msu_pkg::msu_long;
  localparam msu_pkg::msu_op_t op_s = msu_pkg::msu_sat;
  localparam msu_pkg::msu_op_t op_o = msu_pkg::msu_other;
  typedef struct {
    logic                v;
    logic                ill;
    logic                lk;
    int                  n;
    logic [31:0]         pf;
    logic [63:0]         res;
    logic                clip;
    msu_pkg::msu_issue_t t;
  } msu_fl_t;
  logic                clk_i;
  logic                sys_rst_i;
  logic                issue_valid_i;
  msu_pkg::msu_issue_t issue_i;
  msu_pkg::msu_oper_t  oper_i;
  logic [31:0]         prefetch_addr_i;
  logic                ready_o;
  logic                stall_o;
  logic                illegal_o;
  msu_pkg::msu_bus_t   bus_o;
  logic [31:0]         fetch_addr_o;
  logic [63:0]         result_o;
  logic                result_valid_o;
  logic [1:0]          flags_o;
  logic                saturated_o;
  logic [31:0]         fetch_count;
  logic [31:0]         seed = 32'h0001203f;
  int                  miscompares = 0;
  int                  checks = 0;
  int                  cycles = 0;
  int                  legal = 0;
  msu_fl_t             fl;
  msu_fl_t             pr;
  msu_core i_msu_core (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .issue_valid_i(issue_valid_i),
    .issue_i(issue_i), .oper_i(oper_i), .prefetch_addr_i(prefetch_addr_i),
    .ready_o(ready_o), .stall_o(stall_o), .illegal_o(illegal_o), .bus_o(bus_o),
    .fetch_addr_o(fetch_addr_o), .result_o(result_o), .result_valid_o(result_valid_o),
    .flags_o(flags_o), .saturated_o(saturated_o)
  );
  msu_mem_model i_msu_mem_model (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus_o), .fetch_addr_i(fetch_addr_o),
    .fetch_count_o(fetch_count), .fetch_data_o()
  );
  // ****************************************
  // Expectations and drivers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic hit(msu_pkg::msu_issue_t p, logic u, logic [3:0] r);
    return u && (r == p.dst_lo || (p.dst_hi_en && r == p.dst_hi));
  endfunction
  function automatic logic exp_lock(msu_fl_t p, msu_pkg::msu_issue_t c);
    logic ex;
    logic mem;
    ex = hit(p.t, c.use_a, c.src_a) || hit(p.t, c.use_b, c.src_b);
    mem = hit(p.t, c.use_c, c.src_c) || hit(p.t, c.use_c_hi, c.src_c_hi);
    if (!p.v || p.ill || p.t.set_flags || c.set_flags || p.t.op > op_s)
      return 1'h0;
    return ex || (p.t.op < op_s && mem && !(c.op < op_s && c.accumulate));
  endfunction
  function automatic int exp_n(msu_pkg::msu_issue_t t, logic lk);
    case (t.op)
      op_w:                   return t.set_flags ? 4 : 2 + lk;
      op_l:                   return t.set_flags ? 5 : 3 + lk;
      msu_pkg::msu_half_long: return 2 + lk;
      default:                return 1 + lk;
    endcase
  endfunction
  function automatic logic [63:0] exp_res(msu_pkg::msu_issue_t t, msu_pkg::msu_oper_t o);
    logic [63:0] p;
    if (t.is_signed)
      p = $signed(o.a_bus) * $signed(o.b_bus);
    else
      p = o.a_bus * o.b_bus;
    if (t.op == op_w)
      return {32'h0, p[31:0] + (t.accumulate ? o.c_bus : 32'h0)};
    return p + (t.accumulate ? {o.c_hi_bus, o.c_bus} : 64'h0);
  endfunction
  localparam longint sat_hi = 64'sh000000007fffffff;
  localparam longint sat_lo = ~sat_hi;
  // Clips to the signed 32-bit range and notes any clipping in q
  function automatic longint sat32(longint v, inout logic q);
    q = q || v > sat_hi || v < sat_lo;
    if (v > sat_hi)
      return sat_hi;
    if (v < sat_lo)
      return sat_lo;
    return v;
  endfunction
  function automatic logic [63:0] exp_sat(msu_pkg::msu_issue_t t, msu_pkg::msu_oper_t o,
                                          output logic q);
    longint b;
    q = 1'h0;
    b = longint'($signed(o.b_bus));
    if (t.doubling)
      b = sat32(b * 64'sh2, q);
    if (t.subtract)
      b = sat32(longint'($signed(o.a_bus)) - b, q);
    else
      b = sat32(longint'($signed(o.a_bus)) + b, q);
    return {32'h0, b[31:0]};
  endfunction
  function automatic logic [1:0] exp_nz(msu_fl_t p);
    if (p.t.op == op_l)
      return {p.res[63], p.res == 64'h0};
    return {p.res[31], p.res[31:0] == 32'h0};
  endfunction
  function automatic msu_pkg::msu_issue_t gen();
    msu_pkg::msu_issue_t t;
    logic [63:0] r;
    r = {rnd(), rnd()};
    t = r[$bits(t)-1:0];
    t.op = msu_pkg::msu_op_t'(r[2:0] % 3'h7);
    t.compressed = r[63:61] == 3'h0;
    t.set_flags = r[60] && t.op inside {op_w, op_l};
    t.dst_hi_en = t.op inside {op_l, msu_pkg::msu_half_long};
    t.use_c = t.op < op_s ? t.accumulate : t.use_c;
    t.use_c_hi = t.use_c && t.dst_hi_en;
    t.dst_lo[3:2] = 2'h0;
    t.src_a[3:2] = 2'h0;
    t.src_c[3:2] = 2'h0;
    return t;
  endfunction
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (miscompares == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Presents one op and checks the op still in flight until the new one is taken
  task automatic step(input logic v, input msu_pkg::msu_issue_t t);
    msu_fl_t nx;
    msu_pkg::msu_oper_t o;
    int n;
    o = {rnd(), rnd(), rnd(), rnd()};
    nx.v = v;
    nx.t = t;
    nx.pf = rnd();
    nx.res = exp_res(t, o);
    nx.clip = 1'h0;
    if (t.op == op_s)
      nx.res = exp_sat(t, o, nx.clip);
    nx.ill = t.compressed && !(t.op == op_w && t.set_flags);
    nx.lk = v && !nx.ill && exp_lock(fl, t);
    nx.n = nx.ill ? 1 : exp_n(t, nx.lk);
    issue_valid_i <= v;
    issue_i <= t;
    oper_i <= o;
    prefetch_addr_i <= nx.pf;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      if (fl.v && n == 1)
        check("stall", stall_o, fl.lk);
      if (fl.v && n == 1)
        check("refused", illegal_o, fl.ill);
      if (fl.v)
        check("seq_fetch", !bus_o.fetch_request_n, !fl.ill && n == fl.n);
      if (fl.v && !fl.ill)
        check("fetch_addr", fetch_addr_o, fl.pf);
      if (n == 1 && pr.v && !pr.ill && !pr.lk && pr.t.op inside {op_w, op_l, op_s})
        check("result", result_o, pr.res);
      if (n == 1 && pr.v && !pr.ill && !pr.lk && pr.t.op == op_s)
        check("saturated", saturated_o, pr.clip);
      if (n == 1 && pr.v && !pr.ill && pr.t.set_flags)
        check("flags", flags_o, exp_nz(pr));
      check("result_valid", result_valid_o, n == 1 && pr.v && !pr.ill && pr.t.op != op_o);
    end while (!ready_o && n < 8);
    if (fl.v)
      check("cycles", n, fl.n);
    if (v && !nx.ill)
      legal++;
    pr = fl;
    fl = nx;
  endtask
  task automatic pair(input msu_pkg::msu_op_t p, input logic f, input msu_pkg::msu_op_t c,
                      input logic a, input logic m);
    msu_pkg::msu_issue_t t;
    t = '0;
    t.op = p;
    t.set_flags = f;
    t.dst_lo = 4'h9;
    step(1'h1, t);
    t.op = c;
    t.set_flags = 1'h0;
    t.dst_lo = 4'h1;
    {t.use_a, t.src_a} = {a, 4'h9};
    {t.use_c, t.src_c} = {m, 4'h9};
    t.accumulate = m && c < op_s;
    step(1'h1, t);
  endtask
  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    fl.v = 1'h0;
    pr.v = 1'h0;
    sys_rst_i = 1'h1;
    issue_valid_i = 1'h0;
    issue_i = '0;
    oper_i = '0;
    prefetch_addr_i = 32'h0;
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'h0;
    check("reset_bus", bus_o, 4'ha);
    pair(op_w, 1'h0, op_o, 1'h1, 1'h0);
    pair(op_w, 1'h0, op_w, 1'h0, 1'h1);
    pair(op_w, 1'h0, op_o, 1'h0, 1'h1);
    pair(op_s, 1'h0, op_o, 1'h0, 1'h1);
    pair(op_s, 1'h0, op_o, 1'h1, 1'h0);
    pair(op_w, 1'h1, op_o, 1'h1, 1'h0);
    pair(op_l, 1'h1, op_o, 1'h1, 1'h0);
    repeat (400) step(rnd() % 32'h8 != 32'h0, gen());
    repeat (3) step(1'h0, '0);
    check("fetches", fetch_count, legal);
    finish_test();
  end
endmodule
`default_nettype wire
